// ---- wobc_top.sv ----
// option byte loader, ahb-lite register slave and watchdog wrapper
// assumes a flash read port answering with an ack, inputs synchronous
`timescale 1ns/1ps
module wobc_top
    import wobc_pkg::*;
#(
    parameter int LS_DIV = 152
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        boot_swap,
    output logic             flash_req,
    output logic [16:0]      flash_addr,
    input  wire logic        flash_ack,
    input  wire logic [7:0]  flash_rdata,
    input  wire logic        standby,
    input  wire logic        auth_fail,
    output logic             cfg_valid,
    output logic             debug_enable,
    output logic             flash_erase_req,
    output logic             wdt_reset_req,
    output logic             irq
);
    wobc_cfg_if  cfg ();

    wobc_state_t state;
    wobc_state_t next_state;
    logic [7:0]  user_cfg;
    logic [7:0]  debug_cfg;
    logic        swap;

    logic        ap_take;
    logic        ap_map;
    logic [7:0]  ap_idx;
    logic        dp_write;
    logic [7:0]  dp_idx;
    logic        dp_valid;

    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [ST_W-1:0] events;
    logic            status_rd;

    logic [15:0] div_cnt;
    logic        tick;
    logic        kick;
    logic        kick_bad;

    // boot swap is caught once after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            swap <= 1'b0;
        end else if (state == WOBC_FETCH_USR && !flash_req) begin
            swap <= boot_swap; // R5
        end
    end

    // loader sequence: user byte, then debug byte, then run
    always_comb begin
        next_state = state;
        case (state)
            WOBC_FETCH_USR: begin
                if (flash_req && flash_ack) begin
                    next_state = WOBC_FETCH_DBG;
                end
            end
            WOBC_FETCH_DBG: begin
                if (flash_req && flash_ack) begin
                    next_state = WOBC_RUN;
                end
            end
            WOBC_RUN: begin
                next_state = WOBC_RUN; // R9
            end
            default: begin
                next_state = WOBC_FETCH_USR;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= WOBC_FETCH_USR;
        end else begin
            state <= next_state;
        end
    end

    // flash read request, address follows the swap strap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_req  <= 1'b0;
            flash_addr <= '0;
        end else begin
            case (next_state)
                WOBC_FETCH_USR: begin
                    flash_req  <= 1'b1;
                    flash_addr <= boot_swap ? ADDR_USER_SWAP
                                            : ADDR_USER; // R5
                end
                WOBC_FETCH_DBG: begin
                    flash_req  <= 1'b1;
                    // the swapped copy must match, see software notes
                    flash_addr <= swap ? ADDR_DBG_SWAP : ADDR_DBG; // R6 R8
                end
                default: begin
                    flash_req  <= 1'b0;
                    flash_addr <= '0;
                end
            endcase
        end
    end

    // option bytes, written only during the load sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            user_cfg  <= BYTE_RESET;
            debug_cfg <= BYTE_RESET;
        end else if (flash_req && flash_ack) begin
            if (state == WOBC_FETCH_USR) begin
                user_cfg <= flash_rdata; // R9
            end
            if (state == WOBC_FETCH_DBG) begin
                debug_cfg <= flash_rdata; // R9
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_valid <= 1'b0;
        end else begin
            cfg_valid <= (next_state == WOBC_RUN);
        end
    end

    // debug control; debug stays off until the byte is in
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            debug_enable    <= 1'b0;
            flash_erase_req <= 1'b0;
        end else begin
            debug_enable    <= cfg_valid &&
                               debug_cfg[DBG_ENABLE_BIT]; // R6
            flash_erase_req <= cfg_valid && auth_fail &&
                               debug_cfg[DBG_ERASE_BIT]; // R7
        end
    end

    // slow clock enable from a divider of the bus clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else if (div_cnt == 16'(LS_DIV - 1)) begin
            div_cnt <= '0;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h1;
            tick    <= 1'b0;
        end
    end

    // hookup to the counter
    assign cfg.user_cfg = user_cfg;
    assign cfg.run_ok   = cfg_valid;
    assign cfg.tick     = tick;
    assign cfg.standby  = standby;
    assign cfg.kick     = kick;
    assign cfg.kick_bad = kick_bad;

    wobc_wdt u_wdt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cfg     (cfg.wdt)
    );

    // address phase decode, only word-aligned low addresses map
    assign ap_take = hsel && hready && htrans[1];
    assign ap_idx  = haddr[9:2];
    assign ap_map  = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_idx   <= '0;
        end else if (hready) begin
            dp_valid <= ap_take && ap_map;
            dp_write <= hwrite;
            dp_idx   <= ap_idx;
        end
    end

    // zero wait state, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read data prepared in the address phase, unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (ap_take && !hwrite && ap_map) begin
            case (ap_idx)
                IDX_USER:    hrdata <= {24'h0, user_cfg};
                IDX_DEBUG:   hrdata <= {24'h0, debug_cfg};
                IDX_STATUS:  hrdata <= {29'h0, status};
                IDX_MASK:    hrdata <= {29'h0, mask};
                IDX_COUNT:   hrdata <= {11'h0, cfg.count};
                default:     hrdata <= '0;
            endcase
        end else begin
            hrdata <= '0;
        end
    end

    assign status_rd = ap_take && !hwrite && ap_map &&
                       (ap_idx == IDX_STATUS);

    // refresh write: right key inside the window restarts, anything else is a violation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kick     <= 1'b0;
            kick_bad <= 1'b0;
        end else begin
            kick     <= dp_valid && dp_write &&
                        (dp_idx == IDX_REFRESH) &&
                        (hwdata[7:0] == REFRESH_KEY);
            kick_bad <= dp_valid && dp_write &&
                        (dp_idx == IDX_REFRESH) &&
                        (hwdata[7:0] != REFRESH_KEY);
        end
    end

    // mask register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= MASK_RESET;
        end else if (dp_valid && dp_write && dp_idx == IDX_MASK) begin
            mask <= hwdata[ST_W-1:0];
        end
    end

    assign events = {cfg.ev_violate, cfg.ev_overflow, cfg.ev_interval};

    // sticky status, cleared by a read; a same-cycle event survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
        end else if (status_rd) begin
            status <= events;
        end else begin
            status <= status | events; // R1
        end
    end

    // level interrupt, lags status by one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // reset request on overflow, on a refresh with the wrong key, or on a refresh outside the window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= cfg.ev_overflow || cfg.ev_violate; // R2
        end
    end

    // hsize is accepted as a word access only
    logic unused_hsize;
    assign unused_hsize = ^hsize;
endmodule

// ---- wobc_pkg.sv ----
// constants, field layout and helpers for the option byte watchdog block
// assumes one 40 MHz clock and an AHB-Lite master with word accesses
// Functional notes
// R1: interval interrupt at 75% of overflow time when bit 7 set
// R2: bits 6:5 pick window open period of 25, 50, 75 or 100%
// R3: bit 4 set starts the counter after reset, clear keeps it stopped
// R4: bits 3:1 pick overflow of 2^10,11,12,13,15,17,18,20 slow cycles
// R5: user byte fetched from USER_CONFIG_BYTE, from 010C0H under boot swap
// R6: debug byte at DEBUG_CONFIG_BYTE enables or disables on-chip debug
// R7: debug byte selects erase or keep flash on failed ID check
// R8: software keeps 010C3H equal to DEBUG_CONFIG_BYTE when boot swap is used
// R9: both bytes latched at reset and held static until next reset
package wobc_pkg;

    // flash locations of the option bytes
    localparam logic [16:0] ADDR_USER      = 17'h000C0;
    localparam logic [16:0] ADDR_USER_SWAP = 17'h010C0;
    localparam logic [16:0] ADDR_DBG       = 17'h000C3;
    localparam logic [16:0] ADDR_DBG_SWAP  = 17'h010C3;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_USER    = 8'hC0;
    localparam logic [7:0] IDX_DEBUG   = 8'hC3;
    localparam logic [7:0] IDX_REFRESH = 8'hC4;
    localparam logic [7:0] IDX_STATUS  = 8'hC5;
    localparam logic [7:0] IDX_MASK    = 8'hC6;
    localparam logic [7:0] IDX_COUNT   = 8'hC7;

    // user option byte fields
    localparam int INTERVAL_USE_BIT = 7;
    localparam int OPEN_HI_BIT      = 6;
    localparam int OPEN_LO_BIT      = 5;
    localparam int AUTOSTART_BIT    = 4;
    localparam int OVF_HI_BIT       = 3;
    localparam int OVF_LO_BIT       = 1;
    localparam int STANDBY_BIT      = 0;

    // debug option byte fields
    localparam int DBG_ENABLE_BIT = 7;
    localparam int DBG_ERASE_BIT  = 0;

    // status and mask layout
    localparam int ST_INTERVAL = 0;
    localparam int ST_OVERFLOW = 1;
    localparam int ST_VIOLATE  = 2;
    localparam int ST_W        = 3;

    localparam logic [7:0]  REFRESH_KEY  = 8'hAC;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [2:0]  MASK_RESET   = 3'h0;
    localparam logic [2:0]  INTERVAL_Q   = 3'h3;
    localparam int          CNT_W        = 21;

    typedef enum logic [1:0] {
        WOBC_FETCH_USR = 2'b00,
        WOBC_FETCH_DBG = 2'b01,
        WOBC_RUN       = 2'b11
    } wobc_state_t;

    // overflow period in slow clock cycles
    function automatic logic [CNT_W-1:0] wobc_period(input logic [2:0] sel);
        case (sel)
            3'h0:    wobc_period = 21'h000400;
            3'h1:    wobc_period = 21'h000800;
            3'h2:    wobc_period = 21'h001000;
            3'h3:    wobc_period = 21'h002000;
            3'h4:    wobc_period = 21'h008000;
            3'h5:    wobc_period = 21'h020000;
            3'h6:    wobc_period = 21'h040000;
            default: wobc_period = 21'h100000;
        endcase
    endfunction

    // q quarters of a period
    function automatic logic [CNT_W-1:0] wobc_quarters(
        input logic [CNT_W-1:0] p,
        input logic [2:0]       q
    );
        wobc_quarters = CNT_W'((p >> 2) * q);
    endfunction

endpackage

// ---- wobc_cfg_if.sv ----
// carrier between the register side and the watchdog counter
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface wobc_cfg_if;
    import wobc_pkg::*;
    logic [7:0]       user_cfg;
    logic             run_ok;
    logic             tick;
    logic             standby;
    logic             kick;
    logic             kick_bad;
    logic [CNT_W-1:0] count;
    logic             ev_interval;
    logic             ev_overflow;
    logic             ev_violate;
    logic             window_open;

    modport ctl (output user_cfg, run_ok, tick, standby, kick, kick_bad,
                 input count, ev_interval, ev_overflow, ev_violate,
                 window_open);
    modport wdt (input user_cfg, run_ok, tick, standby, kick, kick_bad,
                 output count, ev_interval, ev_overflow, ev_violate,
                 window_open);
endinterface

// ---- wobc_wdt.sv ----
// watchdog counter driven by the slow tick, configured by the user byte
// assumes the config is static once run_ok rises
`timescale 1ns/1ps
module wobc_wdt
    import wobc_pkg::*;
(
    input  wire logic  hclk,
    input  wire logic  hresetn,
    wobc_cfg_if.wdt    cfg
);
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] open_at;
    logic [CNT_W-1:0] irq_at;
    logic             counting;
    logic             step;

    // decoded limits
    assign period  = wobc_period(cfg.user_cfg[OVF_HI_BIT:OVF_LO_BIT]); // R4
    assign irq_at  = wobc_quarters(period, INTERVAL_Q); // R1
    assign open_at = period - wobc_quarters(period,
                     {1'b0, cfg.user_cfg[OPEN_HI_BIT:OPEN_LO_BIT]} + 3'h1); // R2
    assign counting = cfg.run_ok && cfg.user_cfg[AUTOSTART_BIT]; // R3
    // standby pauses only when the user byte asks for it
    assign step = counting && cfg.tick &&
                  !(cfg.standby && !cfg.user_cfg[STANDBY_BIT]);

    // counter and restart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg.count <= '0;
        end else if (counting && cfg.kick && cfg.window_open) begin
            cfg.count <= '0;
        end else if (step) begin
            if (cfg.count == period - 21'h1) begin
                cfg.count <= '0;
            end else begin
                cfg.count <= cfg.count + 21'h1;
            end
        end
    end

    // window flag, registered; read by the restart and violation logic here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg.window_open <= 1'b0;
        end else begin
            cfg.window_open <= (cfg.count >= open_at); // R2
        end
    end

    // one-cycle events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg.ev_interval <= 1'b0;
            cfg.ev_overflow <= 1'b0;
            cfg.ev_violate  <= 1'b0;
        end else begin
            cfg.ev_interval <= step && cfg.user_cfg[INTERVAL_USE_BIT] &&
                               (cfg.count == irq_at - 21'h1); // R1
            cfg.ev_overflow <= step && (cfg.count == period - 21'h1);
            cfg.ev_violate  <= counting && (cfg.kick_bad ||
                               (cfg.kick && !cfg.window_open));
        end
    end
endmodule

// ---- wobc_monitor.sv ----
// concurrent checks on the ports of the option byte watchdog top
// assumes a bind from the testbench top file and a single clock domain
`timescale 1ns/1ps
module wobc_monitor
    import wobc_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        boot_swap,
    input wire logic        flash_req,
    input wire logic [16:0] flash_addr,
    input wire logic        flash_ack,
    input wire logic [7:0]  flash_rdata,
    input wire logic        auth_fail,
    input wire logic        cfg_valid,
    input wire logic        debug_enable,
    input wire logic        flash_erase_req,
    input wire logic        wdt_reset_req,
    input wire logic        irq
);
    logic [7:0]  usr_byte;
    logic [7:0]  dbg_byte;
    logic        rd_phase;
    logic [31:0] rd_addr;

    default clocking mon_cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // own copies of the fetched bytes, so readback has a reference
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            usr_byte <= 8'h00;
            dbg_byte <= 8'h00;
            rd_phase <= 1'b0;
            rd_addr  <= 32'h0;
        end else begin
            if (flash_req && flash_ack && !flash_addr[0]) begin
                usr_byte <= flash_rdata;
            end
            if (flash_req && flash_ack && flash_addr[0]) begin
                dbg_byte <= flash_rdata;
            end
            rd_phase <= hsel && hready && htrans[1] && !hwrite;
            rd_addr  <= haddr;
        end
    end

    a_user_addr: assert property (
        flash_req && !flash_addr[0] |->
        flash_addr == (boot_swap ? ADDR_USER_SWAP : ADDR_USER))
        else $error("user byte fetched from wrong place");
    a_dbg_addr: assert property (
        flash_req && flash_addr[0] |->
        flash_addr == (boot_swap ? ADDR_DBG_SWAP : ADDR_DBG))
        else $error("debug byte fetched from wrong place");
    a_cfg_done: assert property (
        flash_req && flash_ack && flash_addr[0] |=> cfg_valid && !flash_req)
        else $error("config not valid after second fetch");
    a_cfg_hold: assert property (
        cfg_valid |=> cfg_valid && !flash_req)
        else $error("config dropped or refetched before reset");
    a_debug_follow: assert property (
        debug_enable == $past(cfg_valid && dbg_byte[DBG_ENABLE_BIT]))
        else $error("debug enable differs from debug byte");
    a_erase_sel: assert property (
        cfg_valid && auth_fail |=> flash_erase_req == dbg_byte[DBG_ERASE_BIT])
        else $error("erase request does not follow debug byte");
    a_erase_cause: assert property (
        flash_erase_req |-> $past(auth_fail))
        else $error("erase request without failed check");
    a_stopped_quiet: assert property (
        cfg_valid && !usr_byte[AUTOSTART_BIT] |-> !wdt_reset_req && !irq)
        else $error("stopped watchdog produced an event");
    a_irq_source: assert property (
        $rose(irq) |-> cfg_valid && usr_byte[AUTOSTART_BIT])
        else $error("interrupt while watchdog idle");
    a_user_readback: assert property (
        rd_phase && rd_addr == 32'h300 && cfg_valid && $past(cfg_valid)
        |-> hrdata == {24'h0, usr_byte})
        else $error("user byte readback differs from fetched value");

    c_loaded: cover property ($rose(cfg_valid));
    c_irq: cover property ($rose(irq));
    c_erase: cover property (flash_erase_req);
    c_reset_req: cover property (wdt_reset_req);
endmodule

// ---- tb.sv ----
// self-checking bench for the option byte watchdog top
// assumes the checker file and the design files are compiled first
`timescale 1ns/1ps
bind wobc_top wobc_monitor wobc_monitor_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .boot_swap(boot_swap), .flash_req(flash_req),
    .flash_addr(flash_addr), .flash_ack(flash_ack),
    .flash_rdata(flash_rdata), .auth_fail(auth_fail),
    .cfg_valid(cfg_valid), .debug_enable(debug_enable),
    .flash_erase_req(flash_erase_req), .wdt_reset_req(wdt_reset_req),
    .irq(irq));

module tb;
    import wobc_pkg::*;
    localparam int LS = 2;
    localparam int NTAB [8] = '{10, 11, 12, 13, 15, 17, 18, 20};
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    wire         hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        boot_swap;
    logic        flash_req;
    logic [16:0] flash_addr;
    logic        flash_ack;
    logic [7:0]  flash_rdata;
    logic        auth_fail;
    logic        cfg_valid;
    logic        debug_enable;
    logic        flash_erase_req;
    logic        wdt_reset_req;
    logic        irq;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          t0 = 0;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    wobc_top #(.LS_DIV(LS)) wobc_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .boot_swap(boot_swap), .flash_req(flash_req),
        .flash_addr(flash_addr), .flash_ack(flash_ack),
        .flash_rdata(flash_rdata), .standby(1'b0), .auth_fail(auth_fail),
        .cfg_valid(cfg_valid), .debug_enable(debug_enable),
        .flash_erase_req(flash_erase_req), .wdt_reset_req(wdt_reset_req),
        .irq(irq));

    // 40 MHz clock and a free cycle count for timing
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) cyc <= cyc + 1;

    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", w, exp, got);
        end
    endtask

    task automatic rng(input string w, input int lo, hi, v);
        num_checks++;
        if (v < lo || v > hi) begin
            n_mismatch++;
            $display("BAD %s expected %0d..%0d seen %0d", w, lo, hi, v);
        end
    endtask

    task automatic hang(input string w);
        chk(w, 32'h1, 32'h0);
        end_of_test();
    endtask

    // inputs are seen as they stood just before the edge
    task automatic wait_rdy();
        for (int i = 0; i < 40; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        hang("hready");
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= a;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask

    task automatic rd_chk(input string w, input logic [31:0] a, exp);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(w, exp, r);
        chk("hresp", 32'h0, 32'(hresp));
    endtask

    // flash side answers one fetch, data shown only with the ack
    task automatic serve(input logic [16:0] a, input logic [7:0] d);
        for (int i = 0; i <= 20; i++) begin
            @(posedge hclk);
            if (flash_req === 1'b1) break;
            if (i == 20) hang("flash_req");
        end
        chk("flash_addr", 32'(a), 32'(flash_addr));
        flash_ack   <= 1'b1;
        flash_rdata <= d;
        @(posedge hclk);
        flash_ack   <= 1'b0;
        flash_rdata <= ~d;
    endtask

    task automatic boot(input logic [7:0] ub, db, input logic sw);
        hresetn   <= 1'b0;
        boot_swap <= sw;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        serve(sw ? ADDR_USER_SWAP : ADDR_USER, ub);
        serve(sw ? ADDR_DBG_SWAP : ADDR_DBG, db);
        for (int i = 0; i <= 8; i++) begin
            @(posedge hclk);
            if (cfg_valid === 1'b1) break;
            if (i == 8) hang("cfg_valid");
        end
        t0 = cyc;
        // debug enable lags cfg_valid by one flop, look after the reads
        rd_chk("user byte", 32'h300, {24'h0, ub});
        rd_chk("debug byte", 32'h30C, {24'h0, db});
        chk("debug_enable", 32'(db[7]), 32'(debug_enable));
    endtask

    task automatic wait_to(input int t);
        while (cyc - t0 < t) @(posedge hclk);
    endtask

    task automatic s_boot();
        logic [31:0] r;
        boot(8'h4A, 8'h81, 1'b1);
        ahb(1'b1, 32'h300, 32'hFF, r);
        rd_chk("ro write", 32'h300, 32'h4A);
        rd_chk("unmapped", 32'h400, 32'h0);
    endtask

    task automatic s_debug(input logic [7:0] db);
        boot(8'h00, db, 1'b0);
        auth_fail <= 1'b1;
        @(posedge hclk);
        auth_fail <= 1'b0;
        @(posedge hclk);
        chk("erase", 32'(db[0]), 32'(flash_erase_req));
    endtask

    // interval event masked in, overflow left masked out
    task automatic s_ovf(input int code, input logic intr);
        int          per;
        int          irq_at;
        logic [31:0] r;
        per = (1 << NTAB[code]) * LS;
        irq_at = 0;
        boot({intr, 2'b11, 1'b1, 3'(code), 1'b0}, 8'h00, 1'b0);
        ahb(1'b1, 32'h318, 32'h1, r);
        for (int i = 0; i <= per + 64; i++) begin
            @(posedge hclk);
            if (irq === 1'b1 && irq_at == 0) irq_at = cyc - t0;
            if (wdt_reset_req === 1'b1) break;
            if (i == per + 64) hang("overflow");
        end
        rng("overflow time", per - 8, per + LS + 8, cyc - t0);
        rng("interval time", intr ? 3 * per / 4 - 8 : 0,
            intr ? 3 * per / 4 + LS + 8 : 0, irq_at);
        rd_chk("status", 32'h314, {31'h1, intr});
        rd_chk("status cleared", 32'h314, 32'h0);
        chk("irq cleared", 32'h0, 32'(irq));
    endtask

    task automatic s_stop();
        logic [31:0] r;
        boot(8'hE0, 8'h00, 1'b0);
        ahb(1'b1, 32'h318, 32'h7, r);
        ahb(1'b1, 32'h310, 32'(REFRESH_KEY), r);
        wait_to(2 * 2048 + 100);
        rd_chk("stopped status", 32'h314, 32'h0);
        rd_chk("stopped count", 32'h31C, 32'h0);
    endtask

    // refresh at pct of the shortest period, before or inside the window
    task automatic s_win(input int w, pct, input logic [7:0] key,
                         input logic viol);
        logic [31:0] r;
        boot({1'b0, 2'(w), 1'b1, 3'h0, 1'b0}, 8'h00, 1'b0);
        wait_to((1 << NTAB[0]) * LS * pct / 100);
        ahb(1'b1, 32'h310, {24'h0, key}, r);
        repeat (4) @(posedge hclk);
        rd_chk("window status", 32'h314, {29'h0, viol, 2'b00});
    endtask

    // reset and boot_swap are first driven by the boot task
    initial begin
        hsel        = 1'b0;
        haddr       = 32'h0;
        htrans      = 2'h0;
        hwrite      = 1'b0;
        hwdata      = 32'h0;
        flash_ack   = 1'b0;
        flash_rdata = 8'h00;
        auth_fail   = 1'b0;
        s_boot();
        s_debug(8'h81);
        s_debug(8'h00);
        s_debug(8'h01);
        s_ovf(0, 1'b1);
        s_ovf(1, 1'b0);
        s_ovf(2, 1'b1);
        s_ovf(3, 1'b0);
        s_stop();
        for (int w = 0; w < 3; w++) begin
            s_win(w, 70 - 25 * w, REFRESH_KEY, 1'b1);
            s_win(w, 80 - 25 * w, REFRESH_KEY, 1'b0);
        end
        s_win(3, 5, REFRESH_KEY, 1'b0);
        s_win(3, 50, 8'h55, 1'b1);
        end_of_test();
    end
endmodule
